// ===== design/test_mode_io_forcing.sv
// test mode entry, led flashing, apb registers and contact forcing
//
// How it works
// - test mode needs enable and trigger true
// - constant trigger: enabling starts test mode
// - operand trigger: operand rising starts test
// - indicator flashes while test mode active
// - only contact inputs and outputs change
// - disabled input keeps reporting its terminal
// - open input reports zero during test
// - closed input reports one during test
// - all inputs disabled means normal reporting
// - disabled output follows its control operand
// - energize holds output closed during test
// - de-energize holds output open during test
// - freeze holds output's pre-test position
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
module test_mode_io_forcing #(
	parameter int FLASH_HALF_CYCLES = test_force_pkg::FLASH_HALF_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  contact_terminal,
	input  wire logic [7:0]  logic_operands,
	input  wire logic [7:0]  output_operand,
	output logic      [7:0]  contact_input_state,
	output logic      [7:0]  contact_output_drive,
	output logic             test_active,
	output logic             test_led
);

	// ***********************************************
	// declarations
	// ***********************************************
	// last count of a half flash period, cut to the counter width on purpose
	localparam logic [22:0] FLASH_LAST = 23'(FLASH_HALF_CYCLES - 1);

	logic                        enable_q;
	logic                        trig_on_q;
	logic [2:0]                  opsel_q;
	logic [15:0]                 input_force_select_q;
	logic [15:0]                 output_force_select_q;
	logic [31:0]                 prdata_q;
	test_force_pkg::test_state_t state_q;
	test_force_pkg::test_state_t state_d;
	logic                        trigger;
	logic                        led_q;
	logic [22:0]                 flash_cnt_q;
	logic                        wr_en;
	logic                        rd_setup;
	logic                        addr_hit;
	logic [31:0]                 rd_word;
	logic [7:0]                  input_report;
	logic [7:0]                  output_drive;

	// ***********************************************
	// apb access decode
	// ***********************************************
	// no wait states: every access phase ends at its first edge
	assign pready   = psel & penable;
	assign pslverr  = psel & penable & ~addr_hit;
	assign wr_en    = psel & penable & pwrite & addr_hit;
	assign rd_setup = psel & ~penable & ~pwrite;

	// ***********************************************
	// read mux and address hit
	// ***********************************************
	// only the four word offsets answer; anything else flags an error
	always_comb begin
		addr_hit = 1'b1;
		rd_word  = 32'h0000_0000;
		if (paddr == test_force_pkg::CTRL_OFS) begin
			rd_word[test_force_pkg::CTRL_ENABLE_BIT]     = enable_q;
			rd_word[test_force_pkg::CTRL_TRIG_ON_BIT]    = trig_on_q;
			rd_word[test_force_pkg::CTRL_OPSEL_LSB +: 3] = opsel_q;
		end else if (paddr == test_force_pkg::IN_FORCE_OFS) begin
			rd_word[15:0] = input_force_select_q;
		end else if (paddr == test_force_pkg::OUT_FORCE_OFS) begin
			rd_word[15:0] = output_force_select_q;
		end else if (paddr == test_force_pkg::STATUS_OFS) begin
			rd_word[test_force_pkg::STAT_ACTIVE_BIT]     = test_active;
			rd_word[test_force_pkg::STAT_LED_BIT]        = led_q;
			rd_word[test_force_pkg::STAT_INPUT_LSB +: 8] = input_report;
			rd_word[test_force_pkg::STAT_OUTPUT_LSB +: 8] = output_drive;
			rd_word[test_force_pkg::STAT_TERM_LSB +: 8]  = contact_terminal;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// read data captured in the setup cycle so it stands through the access phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= rd_word;
		end
	end
	assign prdata = prdata_q;

	// ***********************************************
	// control registers
	// ***********************************************
	// control word: enable, constant trigger, operand select
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_q  <= test_force_pkg::ENABLE_RST;
			trig_on_q <= test_force_pkg::TRIG_ON_RST;
			opsel_q   <= test_force_pkg::OPSEL_RST;
		end else if (wr_en && paddr == test_force_pkg::CTRL_OFS) begin
			enable_q  <= pwdata[test_force_pkg::CTRL_ENABLE_BIT];
			trig_on_q <= pwdata[test_force_pkg::CTRL_TRIG_ON_BIT];
			opsel_q   <= pwdata[test_force_pkg::CTRL_OPSEL_LSB +: 3];
		end
	end

	// two bits of input force selection per contact input
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			input_force_select_q <= test_force_pkg::IN_FORCE_RST;
		end else if (wr_en && paddr == test_force_pkg::IN_FORCE_OFS) begin
			input_force_select_q <= pwdata[15:0];
		end
	end

	// two bits of output force selection per contact output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			output_force_select_q <= test_force_pkg::OUT_FORCE_RST;
		end else if (wr_en && paddr == test_force_pkg::OUT_FORCE_OFS) begin
			output_force_select_q <= pwdata[15:0];
		end
	end

	// ***********************************************
	// test mode entry
	// ***********************************************
	// trigger source: constant on, or one selected logic operand
	always_comb begin
		if (trig_on_q) begin
			trigger = 1'b1;
		end else begin
			trigger = logic_operands[opsel_q];
		end
	end

	// test mode runs exactly while enable and trigger both hold
	always_comb begin
		state_d = state_q;
		case (state_q)
			test_force_pkg::TEST_IDLE: begin
				if (enable_q && trigger) begin
					state_d = test_force_pkg::TEST_RUN;
				end
			end
			test_force_pkg::TEST_RUN: begin
				if (!(enable_q && trigger)) begin
					state_d = test_force_pkg::TEST_IDLE;
				end
			end
			default: begin
				state_d = test_force_pkg::TEST_IDLE;
			end
		endcase
	end

	// one scan of latency, so forcing starts on a clean edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= test_force_pkg::TEST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	assign test_active = (state_q == test_force_pkg::TEST_RUN);

	// ***********************************************
	// indicator flashing
	// ***********************************************
	// follows state_d so the lamp goes dark in the same cycle test mode ends
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flash_cnt_q <= 23'h00_0000;
			led_q       <= 1'b0;
		end else if (state_d != test_force_pkg::TEST_RUN) begin
			flash_cnt_q <= 23'h00_0000;
			led_q       <= 1'b0;
		end else if (flash_cnt_q == FLASH_LAST) begin
			flash_cnt_q <= 23'h00_0000;
			led_q       <= ~led_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 23'h00_0001;
		end
	end
	assign test_led = led_q;

	// ***********************************************
	// contact forcing cells
	// ***********************************************
	// channel 0
	contact_force_cell cell_0 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[1:0]),
		.out_force_sel   (output_force_select_q[1:0]),
		.terminal_state  (contact_terminal[0]),
		.control_operand (output_operand[0]),
		.input_report    (input_report[0]),
		.output_drive    (output_drive[0])
	);

	// channel 1
	contact_force_cell cell_1 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[3:2]),
		.out_force_sel   (output_force_select_q[3:2]),
		.terminal_state  (contact_terminal[1]),
		.control_operand (output_operand[1]),
		.input_report    (input_report[1]),
		.output_drive    (output_drive[1])
	);

	// channel 2
	contact_force_cell cell_2 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[5:4]),
		.out_force_sel   (output_force_select_q[5:4]),
		.terminal_state  (contact_terminal[2]),
		.control_operand (output_operand[2]),
		.input_report    (input_report[2]),
		.output_drive    (output_drive[2])
	);

	// channel 3
	contact_force_cell cell_3 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[7:6]),
		.out_force_sel   (output_force_select_q[7:6]),
		.terminal_state  (contact_terminal[3]),
		.control_operand (output_operand[3]),
		.input_report    (input_report[3]),
		.output_drive    (output_drive[3])
	);

	// channel 4
	contact_force_cell cell_4 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[9:8]),
		.out_force_sel   (output_force_select_q[9:8]),
		.terminal_state  (contact_terminal[4]),
		.control_operand (output_operand[4]),
		.input_report    (input_report[4]),
		.output_drive    (output_drive[4])
	);

	// channel 5
	contact_force_cell cell_5 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[11:10]),
		.out_force_sel   (output_force_select_q[11:10]),
		.terminal_state  (contact_terminal[5]),
		.control_operand (output_operand[5]),
		.input_report    (input_report[5]),
		.output_drive    (output_drive[5])
	);

	// channel 6
	contact_force_cell cell_6 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[13:12]),
		.out_force_sel   (output_force_select_q[13:12]),
		.terminal_state  (contact_terminal[6]),
		.control_operand (output_operand[6]),
		.input_report    (input_report[6]),
		.output_drive    (output_drive[6])
	);

	// channel 7
	contact_force_cell cell_7 (
		.clk             (clk),
		.reset_n         (reset_n),
		.test_active     (test_active),
		.in_force_sel    (input_force_select_q[15:14]),
		.out_force_sel   (output_force_select_q[15:14]),
		.terminal_state  (contact_terminal[7]),
		.control_operand (output_operand[7]),
		.input_report    (input_report[7]),
		.output_drive    (output_drive[7])
	);

	// only the contact paths are touched; operands pass on unaltered
	assign contact_input_state  = input_report;
	assign contact_output_drive = output_drive;

	// ***********************************************
	// assertions
	// ***********************************************
	// a running test always had enable and trigger one scan earlier
	entry_needs_enable_a : assert property (@(posedge clk) disable iff (!reset_n)
		test_active |-> $past(enable_q && trigger))
		else $error("test mode active without enable and trigger");

	// losing enable or trigger ends test mode on the next scan
	test_exit_a : assert property (@(posedge clk) disable iff (!reset_n)
		(test_active && !(enable_q && trigger)) |=> !test_active)
		else $error("test mode stayed active without enable and trigger");

	// constant trigger: enabling starts test mode
	on_trigger_start_a : assert property (@(posedge clk) disable iff (!reset_n)
		($rose(enable_q) && trig_on_q) |=> test_active)
		else $error("enable with constant trigger did not start test mode");

	// operand trigger: a rising operand starts test mode
	operand_start_a : assert property (@(posedge clk) disable iff (!reset_n)
		(enable_q && !trig_on_q && $rose(trigger)) |=> test_active)
		else $error("rising operand did not start test mode");

	// indicator dark whenever test mode is off
	led_dark_idle_a : assert property (@(posedge clk) disable iff (!reset_n)
		!test_active |-> !test_led)
		else $error("indicator lit outside test mode");

	// indicator toggles at the end of each half period
	led_toggles_a : assert property (@(posedge clk) disable iff (!reset_n)
		(state_d == test_force_pkg::TEST_RUN && flash_cnt_q == FLASH_LAST) |=> (test_led != $past(test_led)))
		else $error("indicator did not toggle at half period");

endmodule : test_mode_io_forcing

// ===== design/test_force_pkg.sv
// constants and types shared by the test mode forcing block
package test_force_pkg;

	// ***********************************************
	// sizes
	// ***********************************************
	localparam int CHANNELS     = 8;
	localparam int OPERANDS     = 8;
	localparam int OPSEL_W      = 3;
	localparam int ADDR_W       = 12;
	localparam int DATA_W       = 32;

	// ***********************************************
	// register byte offsets
	// ***********************************************
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] IN_FORCE_OFS = 12'h004;
	localparam logic [11:0] OUT_FORCE_OFS = 12'h008;
	localparam logic [11:0] STATUS_OFS   = 12'h00C;

	// ***********************************************
	// field positions
	// ***********************************************
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int CTRL_TRIG_ON_BIT = 1;
	localparam int CTRL_OPSEL_LSB   = 4;
	localparam int STAT_ACTIVE_BIT  = 0;
	localparam int STAT_LED_BIT     = 1;
	localparam int STAT_INPUT_LSB   = 8;
	localparam int STAT_OUTPUT_LSB  = 16;
	localparam int STAT_TERM_LSB    = 24;

	// ***********************************************
	// reset values
	// ***********************************************
	localparam logic        ENABLE_RST    = 1'b0;
	localparam logic        TRIG_ON_RST   = 1'b1;
	localparam logic [2:0]  OPSEL_RST     = 3'h0;
	localparam logic [15:0] IN_FORCE_RST  = 16'h0000;
	localparam logic [15:0] OUT_FORCE_RST = 16'h0000;

	// ***********************************************
	// force selections
	// ***********************************************
	localparam logic [1:0] IN_FORCE_OFF    = 2'h0;
	localparam logic [1:0] IN_FORCE_OPEN   = 2'h1;
	localparam logic [1:0] IN_FORCE_CLOSED = 2'h2;
	localparam logic [1:0] OUT_FORCE_OFF   = 2'h0;
	localparam logic [1:0] OUT_FORCE_ON    = 2'h1;
	localparam logic [1:0] OUT_FORCE_DROP  = 2'h2;
	localparam logic [1:0] OUT_FORCE_HOLD  = 2'h3;

	// test mode states
	typedef enum logic {
		TEST_IDLE = 1'b0,
		TEST_RUN  = 1'b1
	} test_state_t;

	// ***********************************************
	// timing
	// ***********************************************
	localparam int CLK_HZ        = 20_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int FLASH_CNT_W   = 23;

endpackage : test_force_pkg

// ===== design/contact_force_cell.sv
// one contact input and one contact output with their test forcing
`timescale 1ns/100ps
module contact_force_cell (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       test_active,
	input  wire logic [1:0] in_force_sel,
	input  wire logic [1:0] out_force_sel,
	input  wire logic       terminal_state,
	input  wire logic       control_operand,
	output logic            input_report,
	output logic            output_drive
);

	logic input_report_q;
	logic output_drive_q;

	// reported input state; reserved code acts as disabled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			input_report_q <= 1'b0;
		end else if (test_active && in_force_sel == test_force_pkg::IN_FORCE_OPEN) begin
			input_report_q <= 1'b0;
		end else if (test_active && in_force_sel == test_force_pkg::IN_FORCE_CLOSED) begin
			input_report_q <= 1'b1;
		end else begin
			input_report_q <= terminal_state;
		end
	end

	// output contact; freeze simply stops updating, so the pre-test position stays
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			output_drive_q <= 1'b0;
		end else if (!test_active) begin
			output_drive_q <= control_operand;
		end else begin
			case (out_force_sel)
				test_force_pkg::OUT_FORCE_ON: begin
					output_drive_q <= 1'b1;
				end
				test_force_pkg::OUT_FORCE_DROP: begin
					output_drive_q <= 1'b0;
				end
				test_force_pkg::OUT_FORCE_HOLD: begin
					output_drive_q <= output_drive_q;
				end
				default: begin
					output_drive_q <= control_operand;
				end
			endcase
		end
	end

	// forced input and output levels, one scan after the selection is seen
	open_reads_zero_a : assert property (@(posedge clk) disable iff (!reset_n)
		(test_active && in_force_sel == test_force_pkg::IN_FORCE_OPEN) |=> !input_report)
		else $error("open forced input did not report zero");

	closed_reads_one_a : assert property (@(posedge clk) disable iff (!reset_n)
		(test_active && in_force_sel == test_force_pkg::IN_FORCE_CLOSED) |=> input_report)
		else $error("closed forced input did not report one");

	energize_closed_a : assert property (@(posedge clk) disable iff (!reset_n)
		(test_active && out_force_sel == test_force_pkg::OUT_FORCE_ON) |=> output_drive)
		else $error("energized output not closed");

	deenergize_open_a : assert property (@(posedge clk) disable iff (!reset_n)
		(test_active && out_force_sel == test_force_pkg::OUT_FORCE_DROP) |=> !output_drive)
		else $error("de-energized output not open");

	freeze_holds_a : assert property (@(posedge clk) disable iff (!reset_n)
		(test_active && out_force_sel == test_force_pkg::OUT_FORCE_HOLD) |=> $stable(output_drive))
		else $error("frozen output moved");

	idle_follows_a : assert property (@(posedge clk) disable iff (!reset_n)
		!test_active |=> (output_drive == $past(control_operand)))
		else $error("output not following its operand outside test mode");

	assign input_report = input_report_q;
	assign output_drive = output_drive_q;

endmodule : contact_force_cell

// ===== sim/field_wiring.sv
// field wiring model feeding the contact terminals
`timescale 1ns/100ps
module field_wiring (
	input  wire logic       clk,
	input  wire logic [7:0] volts,
	output logic      [7:0] terminal
);
	// terminal level lands one scan late, like a real input stage
	always_ff @(posedge clk) begin
		terminal <= volts;
	end
endmodule : field_wiring

// ===== sim/test_mode_io_forcing_tb_top.sv
// self-checking bench for test mode forcing
`timescale 1ns/100ps
module test_mode_io_forcing_tb_top;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, test_active, test_led, lp, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] volts = 8'h00, ops = 8'h00, opnd = 8'h00, term, cin, cout;
	int n_errors = 0, cmp_count = 0, k;
	// terminal, operand, expected input report, expected output drive
	logic [31:0] rows [3] = '{32'hFF00FD0A, 32'h00FF04FB, 32'h0FF00DFA};
	always #25 clk = ~clk;
	field_wiring wire_m (.clk(clk), .volts(volts), .terminal(term));
	// short flash period keeps the run small
	test_mode_io_forcing #(.FLASH_HALF_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .contact_terminal(term), .logic_operands(ops), .output_operand(opnd),
		.contact_input_state(cin), .contact_output_drive(cout), .test_active(test_active), .test_led(test_led));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic give_verdict;
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			n_errors++;
			give_verdict();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask : apb
	task automatic settle(input string t);
		repeat (3) @(posedge clk);
		$display("done %s", t);
	endtask : settle
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1;
		apb(0, 12'h000, 0);
		chk(rd & 32'h73, 32'h02, "ctrl reset");
		chk(test_active, 0, "idle");
		apb(1, 12'h004, 32'h24);
		apb(1, 12'h008, 32'hE4);
		volts <= 8'hA5;
		opnd <= 8'h08;
		settle("unforced");
		chk({cin, cout}, 16'hA508, "unforced io");
		apb(1, 12'h000, 32'h3);
		settle("on trigger");
		chk(test_active, 1, "on trigger");
		for (int i = 0; i < 3; i++) begin
			volts <= rows[i][31:24];
			opnd <= rows[i][23:16];
			settle("row");
			chk({cin, cout}, rows[i][15:0], "forced io");
		end
		k = 0;
		lp = test_led;
		repeat (40) begin
			@(posedge clk);
			if (test_led !== lp) k++;
			lp = test_led;
		end
		chk(k > 6 && k < 14, 1, "flash");
		apb(1, 12'h000, 32'h51);
		settle("operand low");
		chk(test_active, 0, "operand low");
		ops <= 8'h20;
		settle("operand high");
		apb(0, 12'h00C, 0);
		chk(rd[0], 1, "operand high");
		apb(1, 12'h004, 0);
		settle("inputs released");
		chk(cin, 8'h0F, "inputs normal");
		ops <= 8'h00;
		settle("test end");
		chk(cout, 8'hF0, "outputs follow");
		apb(1, 12'h010, 32'hFFFF);
		chk(err, 1, "bad address error");
		apb(0, 12'h000, 0);
		chk(err, 0, "good address no error");
		chk(rd & 32'h73, 32'h51, "ctrl kept");
		reset_n <= 0;
		settle("mid reset");
		chk({test_active, test_led, cout}, 10'h000, "reset outputs");
		reset_n <= 1;
		apb(0, 12'h000, 0);
		chk(rd & 32'h73, 32'h02, "ctrl after reset");
		give_verdict();
	end
endmodule : test_mode_io_forcing_tb_top
